// file: hdl/shp_defs.vh
`ifndef SHP_DEFS_VH
`define SHP_DEFS_VH

// byte framing
`define SHP_BYTE_W      8
`define SHP_BIT_CNT_W   3
`define SHP_BIT_LAST    3'h7
`define SHP_BIT_ZERO    3'h0
`define SHP_BYTE_ZERO   8'h00

// fifo geometry
`define SHP_FIFO_W      8
`define SHP_FIFO_DEPTH  32
`define SHP_FIFO_AW     5

// clock mode field
`define SHP_MODE_W      2
`define SHP_MODE_CPOL   1
`define SHP_MODE_CPHA   0
`define SHP_MODE_RST    2'h0

`endif

// file: hdl/shp_spi_client.v
// Notes on behaviour
// - strap high enables this spi client; strap low hands pins to sd client
// - with strap high the port accepts frames that start after the first clock edge past reset release
// - select is active low; client answers only while select is low
// - data output is released to high impedance while select is high
// - full duplex: receive on host-out, transmit on host-in, same frame
// - all four clock modes are supported via polarity and phase inputs
// - rx bytes go to the register engine, tx bytes come from it
`timescale 1ns/1ps
`include "shp_defs.vh"

////////////////////////////////////////////////////////////////////////////
module shp_fifo
#(
  parameter W     = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
)
(
  input  wire         ref_clk,   // system clock
  input  wire         resetn,    // sync reset, active low
  input  wire         clr,       // flush contents
  input  wire [W-1:0] in_data,   // write data
  input  wire         in_valid,  // write request
  output wire         in_ready,  // not full
  output wire [W-1:0] out_data,  // head data
  output wire         out_valid, // not empty
  input  wire         out_ready  // head consumed
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0]  wr_ptr_reg;
  reg [AW:0]  rd_ptr_reg;
  wire        full;
  wire        empty;
  wire        do_wr;
  wire        do_rd;

  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                     (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign do_wr     = in_valid && !full;
  assign do_rd     = out_ready && !empty;

  always @(posedge ref_clk)
  begin
    if (do_wr)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  always @(posedge ref_clk)
  begin
    if (!resetn || clr)
    begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
      if (do_rd)
        rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module shp_spi_client
(
  input  wire                   ref_clk,         // 200 MHz system clock
  input  wire                   resetn,          // sync reset, active low
  input  wire                   spi_sel_strap,   // 1 = spi client enabled
  input  wire                   cpol,            // clock idle level
  input  wire                   cpha,            // sample on second edge
  input  wire                   sclk,            // serial clock from host
  input  wire                   client_select_n, // client select, low
  input  wire                   mosi,            // host-out data
  output reg                    miso_o,          // host-in data value
  output reg                    miso_oe,         // high while driving
  output reg  [`SHP_BYTE_W-1:0] rx_data,         // received byte
  output reg                    rx_valid,        // received byte pulse
  input  wire [`SHP_BYTE_W-1:0] tx_data,         // byte to send
  input  wire                   tx_valid,        // tx byte offered
  output reg                    tx_ready,        // tx fifo has room
  output reg                    rx_overrun,      // reserved, always low
  output reg                    busy             // frame in progress
);
  reg                      sclk_reg;
  reg                      sel_n_reg;
  reg [`SHP_BIT_CNT_W-1:0] bit_cnt_reg;
  reg [`SHP_BYTE_W-1:0]    rx_sh_reg;
  reg [`SHP_BYTE_W-1:0]    tx_sh_reg;
  reg                      mode_cpol_reg;
  reg                      mode_cpha_reg;
  reg                      strap_reg;
  reg                      first_reg;

  wire                     active;
  wire                     lead_edge;
  wire                     trail_edge;
  wire                     sample_edge;
  wire                     shift_edge;
  wire                     frame_start;
  wire                     byte_done;
  wire [`SHP_BYTE_W-1:0]   rx_byte;
  wire [`SHP_BYTE_W-1:0]   txf_data;
  wire                     txf_valid;
  wire                     txf_pop;
  wire                     txf_ready;
  wire                     tx_load;

  ////////////////////////////////////////////////////////////////////////////
  // edge detection; inputs are synchronous so one register is enough

  assign active      = strap_reg && !client_select_n;
  assign frame_start = active && sel_n_reg;
  assign lead_edge   = active && !sel_n_reg &&
                       (sclk != sclk_reg) && (sclk_reg == mode_cpol_reg);
  assign trail_edge  = active && !sel_n_reg &&
                       (sclk != sclk_reg) && (sclk_reg != mode_cpol_reg);
  assign sample_edge = mode_cpha_reg ? trail_edge : lead_edge;
  assign shift_edge  = mode_cpha_reg ? lead_edge  : trail_edge;
  assign rx_byte     = {rx_sh_reg[`SHP_BYTE_W-2:0], mosi};
  assign byte_done   = sample_edge && (bit_cnt_reg == `SHP_BIT_LAST);
  // a new tx byte enters the shifter on the first shift edge of each
  // byte, except the first one of a cpha=1 frame where bit 7 already
  // stands; the fifo is popped on that same edge so no byte is skipped
  assign tx_load     = shift_edge && (bit_cnt_reg == `SHP_BIT_ZERO) &&
                       !(first_reg && mode_cpha_reg);
  assign txf_pop     = tx_load && txf_valid;

  // one stage of history: the pins are already synchronous to ref_clk
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      sclk_reg  <= 1'b0;
      sel_n_reg <= 1'b1;
      strap_reg <= 1'b0;
    end
    else
    begin
      sclk_reg  <= sclk;
      sel_n_reg <= client_select_n;
      strap_reg <= spi_sel_strap;
    end
  end

  // mode is latched between frames so it cannot change mid byte
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      mode_cpol_reg <= 1'b0;
      mode_cpha_reg <= 1'b0;
    end
    else if (client_select_n)
    begin
      mode_cpol_reg <= cpol;
      mode_cpha_reg <= cpha;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit counter and frame bookkeeping

  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      bit_cnt_reg <= `SHP_BIT_ZERO;
      first_reg   <= 1'b0;
    end
    else if (!active)
    begin
      // a partial byte is dropped when select rises
      bit_cnt_reg <= `SHP_BIT_ZERO;
      first_reg   <= 1'b0;
    end
    else if (frame_start)
    begin
      bit_cnt_reg <= `SHP_BIT_ZERO;
      first_reg   <= 1'b1;
    end
    else
    begin
      // samples taken so far in the current byte; wraps after bit 0
      if (sample_edge)
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      // in cpha=1 the first leading edge presents bit 7 already loaded
      if (shift_edge && first_reg && mode_cpha_reg)
        first_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive shifter

  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      rx_sh_reg  <= `SHP_BYTE_ZERO;
      rx_data    <= `SHP_BYTE_ZERO;
      rx_valid   <= 1'b0;
      rx_overrun <= 1'b0;
    end
    else
    begin
      rx_valid   <= 1'b0;
      rx_overrun <= 1'b0;
      if (sample_edge)
      begin
        rx_sh_reg <= rx_byte;
        if (byte_done)
        begin
          rx_data  <= rx_byte;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit shifter; an empty fifo makes the client send zero bytes,
  // which the host cannot tell from real data

  always @(posedge ref_clk)
  begin
    if (!resetn)
      tx_sh_reg <= `SHP_BYTE_ZERO;
    else if (frame_start || tx_load)
      tx_sh_reg <= txf_valid ? txf_data : `SHP_BYTE_ZERO;
    // the first cpha=1 leading edge keeps bit 7 on the pin
    else if (shift_edge && !(first_reg && mode_cpha_reg))
      tx_sh_reg <= {tx_sh_reg[`SHP_BYTE_W-2:0], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      miso_o  <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      // released on the clock after select rises; value path has one cycle lag
      miso_oe <= active;
      miso_o  <= active ? tx_sh_reg[`SHP_BYTE_W-1] : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs; tx_ready lags the fifo by one cycle because every
  // output comes from a flip-flop, so a writer should keep a slot spare

  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      busy     <= 1'b0;
      tx_ready <= 1'b0;
    end
    else
    begin
      busy     <= active;
      tx_ready <= txf_ready;
    end
  end

  // the rx side keeps no buffer and the host gives no back-pressure, so
  // rx_overrun is reserved and stays low; the tx fifo stalls the register
  // engine through tx_ready
  ////////////////////////////////////////////////////////////////////////////
  shp_fifo
  #(
    .W     (`SHP_FIFO_W),
    .DEPTH (`SHP_FIFO_DEPTH),
    .AW    (`SHP_FIFO_AW)
  )
  u_tx_fifo
  (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clr       (1'b0),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (txf_ready),
    .out_data  (txf_data),
    .out_valid (txf_valid),
    .out_ready (txf_pop | (frame_start & txf_valid))
  );
endmodule

// file: verif/shp_spi_client_assertions.sv
`timescale 1ns/1ps
module shp_spi_client_assertions (
  input wire       ref_clk,         // clock
  input wire       resetn,          // reset
  input wire       spi_sel_strap,   // strap
  input wire       sclk,            // host clock
  input wire       client_select_n, // select
  input wire       miso_o,          // data out
  input wire       miso_oe,         // drive
  input wire [7:0] rx_data,         // rx byte
  input wire       rx_valid,        // rx pulse
  input wire       tx_ready,        // room
  input wire       busy             // active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  strap_off_a: assert property (!spi_sel_strap[*3] |->
    !miso_oe && !rx_valid && !busy) else $error("strap low yet active");
  ready_start_a: assert property ($rose(resetn) |-> ##[1:2] tx_ready)
    else $error("no room after reset");
  select_drive_a: assert property (spi_sel_strap[*3] ##0
    $fell(client_select_n) |-> ##[1:2] miso_oe) else $error("not driving");
  desel_idle_a: assert property (client_select_n[*2] |-> !busy)
    else $error("busy while deselected");
  idle_float_a: assert property (client_select_n[*2] |->
    !miso_oe && !miso_o) else $error("miso driven while deselected");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("rx pulse too long");
  rx_hold_a: assert property (!rx_valid |-> $stable(rx_data))
    else $error("rx byte changed without pulse");
  out_edge_a: assert property ($stable(sclk)[*5] ##0
    $stable(client_select_n)[*5] |-> $stable(miso_o))
    else $error("miso moved without clock edge");
endmodule
bind shp_spi_client shp_spi_client_assertions chk (.ref_clk, .resetn,
  .spi_sel_strap, .sclk, .client_select_n, .miso_o, .miso_oe, .rx_data,
  .rx_valid, .tx_ready, .busy);

// file: verif/shp_host_model.sv
`timescale 1ns/1ps
module shp_host_model (
  input  wire ref_clk,         // system clock
  input  wire miso,            // resolved host-in
  output reg  sclk,            // serial clock
  output reg  client_select_n, // select, low
  output reg  mosi             // host-out
);
  initial
  begin
    sclk = 1'b0;
    client_select_n = 1'b1;
    mosi = 1'b0;
  end
  task wt(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  task sel(input cp);
    sclk = cp;
    wt(4);
    client_select_n = 1'b0;
    wt(4);
  endtask
  task desel;
    wt(6);
    client_select_n = 1'b1;
    mosi = ~mosi; // a held bit would hide a sampling slip
    wt(4);
  endtask
  // six cycles a level keeps well above the two the client needs
  task xfer(input ph, input [7:0] d, output [7:0] q);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
    begin
      if (!ph) mosi = d[i];
      wt(6);
      sclk = ~sclk;
      if (ph) mosi = d[i];
      else q[i] = miso;
      wt(6);
      if (ph) q[i] = miso;
      sclk = ~sclk;
    end
  endtask
endmodule

// file: verif/shp_spi_client_bench.sv
`timescale 1ns/1ps
module shp_spi_client_bench;
  reg        ref_clk, resetn, spi_sel_strap, cpol, cpha, tx_valid;
  reg  [7:0] tx_data;
  wire       sclk, client_select_n, mosi, miso_o, miso_oe;
  wire       rx_valid, tx_ready, rx_overrun, busy;
  wire [7:0] rx_data;
  wire       miso = miso_oe ? miso_o : 1'bz;
  reg  [7:0] got;
  reg  [7:0] rx_q[$];
  integer    err_count = 0;
  integer    n_checks = 0;
  shp_spi_client DUT (.ref_clk, .resetn, .spi_sel_strap, .cpol, .cpha,
    .sclk, .client_select_n, .mosi, .miso_o, .miso_oe, .rx_data, .rx_valid,
    .tx_data, .tx_valid, .tx_ready, .rx_overrun, .busy);
  shp_host_model host (.ref_clk, .miso, .sclk, .client_select_n, .mosi);
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  integer    n_ovr = 0;
  // sampled mid cycle, clear of the edge that launches the outputs
  always @(negedge ref_clk)
  begin
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
    if (resetn && rx_overrun !== 1'b0) n_ovr = n_ovr + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input [8*6:1] what, input [7:0] exp, input [7:0] act);
    n_checks = n_checks + 1;
    if (act !== exp)
    begin
      err_count = err_count + 1;
      $display("FAIL %0s expected %h seen %h", what, exp, act);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one cycle gap lets the late room flag settle before the next offer
  task push(input [7:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    @(negedge ref_clk);
    tx_valid = 1'b0;
    @(negedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_modes;
    integer m;
    for (m = 0; m < 4; m = m + 1)
    begin
      {cpol, cpha} = m[1:0];
      push(8'hA5 ^ m[7:0]);
      rx_q.delete();
      host.sel(cpol);
      host.xfer(cpha, 8'h3C + m[7:0], got);
      host.desel;
      chk("miso", 8'hA5 ^ m[7:0], got);
      chk("rxcnt", 8'h01, 8'(rx_q.size()));
      chk("rx", 8'h3C + m[7:0], rx_q[0]);
    end
    $display("modes done");
  endtask
  task t_fifo;
    integer i;
    {cpol, cpha} = 2'b00;
    for (i = 0; i < 32; i = i + 1)
      push(8'h40 + i[7:0]);
    chk("ready", 8'h00, {7'h00, tx_ready});
    push(8'hEE);
    rx_q.delete();
    host.sel(1'b0);
    for (i = 0; i < 33; i = i + 1)
    begin
      host.xfer(1'b0, i[7:0], got);
      chk("drain", i < 32 ? 8'h40 + i[7:0] : 8'h00, got);
    end
    host.desel;
    chk("ready", 8'h01, {7'h00, tx_ready});
    chk("rxcnt", 8'h21, 8'(rx_q.size()));
    chk("rx", 8'h20, rx_q[32]);
    chk("ovrun", 8'h00, n_ovr[7:0]);
    $display("buffer done");
  endtask
  task t_strap;
    spi_sel_strap = 1'b0;
    rx_q.delete();
    host.wt(3);
    host.sel(1'b0);
    host.xfer(1'b0, 8'h5A, got);
    chk("oe", 8'h00, {7'h00, miso_oe});
    host.desel;
    chk("rxcnt", 8'h00, 8'(rx_q.size()));
    spi_sel_strap = 1'b1;
    host.wt(3);
    $display("strap done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    spi_sel_strap = 1'b1;
    {cpol, cpha, tx_valid} = 3'h0;
    tx_data = 8'h00;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_modes;
    t_fifo;
    t_strap;
    final_report;
  end
  initial
  begin
    #100000;
    err_count = err_count + 1;
    $display("watchdog expired");
    final_report;
  end
endmodule
